/* File: src/smx_pkg.sv */
// constants shared by the shift/move execute block and its pointer stepper
// assumes a single core clock and an external data memory with same-cycle read
package smx_pkg;

  // instruction codes presented by decode on INSTR_OP
  localparam logic [2:0] OP_NONE        = 3'h0;
  localparam logic [2:0] OP_LSR         = 3'h1;
  localparam logic [2:0] OP_FILE_MOVE   = 3'h2;
  localparam logic [2:0] OP_IND_LOAD    = 3'h3;
  localparam logic [2:0] OP_BANK_LIT    = 3'h4;
  localparam logic [2:0] OP_PAGE_LIT    = 3'h5;
  localparam logic [2:0] OP_W_LIT       = 3'h6;

  // pointer update modes of the indirect load
  localparam logic [1:0] MODE_PRE_INC   = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC   = 2'h1;
  localparam logic [1:0] MODE_POST_INC  = 2'h2;
  localparam logic [1:0] MODE_POST_DEC  = 2'h3;
  localparam int         MODE_DEC_BIT   = 0;
  localparam int         MODE_POST_BIT  = 1;

  // file addresses of the two indirect windows
  localparam logic [6:0] WIN0_FILE      = 7'h00;
  localparam logic [6:0] WIN1_FILE      = 7'h01;

  // operand field widths
  localparam int         FILE_W         = 7;
  localparam int         BANK_W         = 5;
  localparam int         PAGE_W         = 7;
  localparam int         OFS_W          = 6;

  // register port offsets
  localparam logic [3:0] REG_W          = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h1;
  localparam logic [3:0] REG_BANK       = 4'h2;
  localparam logic [3:0] REG_PAGE       = 4'h3;
  localparam logic [3:0] REG_FP0_LO     = 4'h4;
  localparam logic [3:0] REG_FP0_HI     = 4'h5;
  localparam logic [3:0] REG_FP1_LO     = 4'h6;
  localparam logic [3:0] REG_FP1_HI     = 4'h7;
  localparam logic [3:0] REG_RETIRED    = 4'h8;

  // status field positions
  localparam int         STAT_C_BIT     = 0;
  localparam int         STAT_Z_BIT     = 1;

  // reset values
  localparam logic [7:0] W_RST          = 8'h00;
  localparam logic       C_RST          = 1'b0;
  localparam logic       Z_RST          = 1'b0;
  localparam logic [4:0] BANK_RST       = 5'h00;
  localparam logic [6:0] PAGE_RST       = 7'h00;
  localparam logic [7:0] RETIRED_RST    = 8'h00;

endpackage

/* File: src/smx_ptr_step.sv */
// one file pointer stepper: effective address and pointer after an indirect load
// assumes the caller holds the pointer register and picks which stepper applies
`timescale 1ns/1ps
module smx_ptr_step #(
  parameter int PTR_W = 16
) (
  input  wire logic [PTR_W-1:0]             ptr,
  input  wire logic [1:0]                   mode,
  input  wire logic                         rel,
  input  wire logic [smx_pkg::OFS_W-1:0]    offset,
  output logic      [PTR_W-1:0]             eff_addr,
  output logic      [PTR_W-1:0]             ptr_next
);

  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PTR_W-1:0] ptr_ofs;
  logic [PTR_W-1:0] ofs_ext;
  logic [PTR_W-1:0] ptr_step;

  // the offset sign extension needs room above the offset field
  if (PTR_W <= smx_pkg::OFS_W) begin : g_bad_ptr_w
    $error("smx_ptr_step: PTR_W must exceed OFS_W");
  end

  // natural modulo arithmetic gives the wrap at both ends
  assign ptr_inc  = ptr + PTR_W'(1);
  assign ptr_dec  = ptr - PTR_W'(1);
  assign ofs_ext  = {{(PTR_W-smx_pkg::OFS_W){offset[smx_pkg::OFS_W-1]}}, offset};
  assign ptr_ofs  = ptr + ofs_ext;
  assign ptr_step = mode[smx_pkg::MODE_DEC_BIT] ? ptr_dec : ptr_inc;

  // pre modes access the stepped value, post modes the old one
  assign eff_addr = rel ? ptr_ofs :
                    (mode[smx_pkg::MODE_POST_BIT] ? ptr : ptr_step);
  assign ptr_next = rel ? ptr : ptr_step;

endmodule

/* File: src/smx_core.sv */
// execute stage for shift, file move, indirect load and literal load instructions
// assumes decode presents one instruction per cycle and data memory reads in the same cycle
`timescale 1ns/1ps
module smx_core #(
  parameter int PTR_W = 16
) (
  input  wire logic                         CLK,
  input  wire logic                         RST_B,
  input  wire logic                         INSTR_VALID,
  input  wire logic [2:0]                   INSTR_OP,
  input  wire logic                         INSTR_DEST,
  input  wire logic [smx_pkg::FILE_W-1:0]   INSTR_FILE,
  input  wire logic [7:0]                   INSTR_LIT,
  input  wire logic                         INSTR_PTR_SEL,
  input  wire logic                         INSTR_REL,
  input  wire logic [1:0]                   INSTR_MODE,
  output logic                              INSTR_DONE,
  output logic      [PTR_W-1:0]             MEM_RADDR,
  input  wire logic [7:0]                   MEM_RDATA,
  output logic                              MEM_WE,
  output logic      [PTR_W-1:0]             MEM_WADDR,
  output logic      [7:0]                   MEM_WDATA,
  output logic      [7:0]                   W_OUT,
  output logic                              C_FLAG,
  output logic                              Z_FLAG,
  output logic      [smx_pkg::BANK_W-1:0]   BANK_OUT,
  output logic      [smx_pkg::PAGE_W-1:0]   PAGE_OUT,
  input  wire logic [3:0]                   REG_ADDR,
  input  wire logic [7:0]                   REG_WDATA,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  output logic      [7:0]                   REG_RDATA
);

  if (PTR_W != 16) begin : g_bad_ptr_w
    $error("smx_core: PTR_W must be 16");
  end

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  logic [7:0]                 w_reg;
  logic [7:0]                 w_next;
  logic                       c_reg;
  logic                       c_next;
  logic                       z_reg;
  logic                       z_next;
  logic [smx_pkg::BANK_W-1:0] bank_reg;
  logic [smx_pkg::BANK_W-1:0] bank_next;
  logic [smx_pkg::PAGE_W-1:0] page_reg;
  logic [smx_pkg::PAGE_W-1:0] page_next;
  logic [PTR_W-1:0]           fp0_reg;
  logic [PTR_W-1:0]           fp0_next;
  logic [PTR_W-1:0]           fp1_reg;
  logic [PTR_W-1:0]           fp1_next;
  logic [7:0]                 retired_reg;
  logic [7:0]                 retired_next;
  logic                       done_reg;
  logic                       mem_we_reg;
  logic [PTR_W-1:0]           mem_waddr_reg;
  logic [7:0]                 mem_wdata_reg;
  logic [7:0]                 rdata_reg;
  logic [7:0]                 rdata_next;

  // instruction decode
  wire is_lsr  = INSTR_VALID && (INSTR_OP == smx_pkg::OP_LSR);
  wire is_mov  = INSTR_VALID && (INSTR_OP == smx_pkg::OP_FILE_MOVE);
  wire is_ind  = INSTR_VALID && (INSTR_OP == smx_pkg::OP_IND_LOAD);
  wire is_bank = INSTR_VALID && (INSTR_OP == smx_pkg::OP_BANK_LIT);
  wire is_page = INSTR_VALID && (INSTR_OP == smx_pkg::OP_PAGE_LIT);
  wire is_wlit = INSTR_VALID && (INSTR_OP == smx_pkg::OP_W_LIT);
  wire is_file = is_lsr || is_mov;
  wire is_known = is_file || is_ind || is_bank || is_page || is_wlit;

  // register port write decode
  wire wr_w      = REG_WR && (REG_ADDR == smx_pkg::REG_W);
  wire wr_status = REG_WR && (REG_ADDR == smx_pkg::REG_STATUS);
  wire wr_bank   = REG_WR && (REG_ADDR == smx_pkg::REG_BANK);
  wire wr_page   = REG_WR && (REG_ADDR == smx_pkg::REG_PAGE);
  wire wr_fp0_lo = REG_WR && (REG_ADDR == smx_pkg::REG_FP0_LO);
  wire wr_fp0_hi = REG_WR && (REG_ADDR == smx_pkg::REG_FP0_HI);
  wire wr_fp1_lo = REG_WR && (REG_ADDR == smx_pkg::REG_FP1_LO);
  wire wr_fp1_hi = REG_WR && (REG_ADDR == smx_pkg::REG_FP1_HI);
  wire wr_fp0    = wr_fp0_lo || wr_fp0_hi;
  wire wr_fp1    = wr_fp1_lo || wr_fp1_hi;

  // pointer steppers, one per file pointer
  logic [PTR_W-1:0] eff0;
  logic [PTR_W-1:0] eff1;
  logic [PTR_W-1:0] step0;
  logic [PTR_W-1:0] step1;

  smx_ptr_step #(.PTR_W(PTR_W)) u_step0 (
    .ptr      (fp0_reg),
    .mode     (INSTR_MODE),
    .rel      (INSTR_REL),
    .offset   (INSTR_LIT[smx_pkg::OFS_W-1:0]),
    .eff_addr (eff0),
    .ptr_next (step0)
  );

  smx_ptr_step #(.PTR_W(PTR_W)) u_step1 (
    .ptr      (fp1_reg),
    .mode     (INSTR_MODE),
    .rel      (INSTR_REL),
    .offset   (INSTR_LIT[smx_pkg::OFS_W-1:0]),
    .eff_addr (eff1),
    .ptr_next (step1)
  );

  // direct addressing: bank select above the 7-bit file field
  wire [PTR_W-1:0] direct_addr =
    PTR_W'({bank_reg, INSTR_FILE});
  wire win0 = (INSTR_FILE == smx_pkg::WIN0_FILE);
  wire win1 = (INSTR_FILE == smx_pkg::WIN1_FILE);
  // window registers hold nothing; the pointer's target is used instead
  wire [PTR_W-1:0] file_addr = win0 ? fp0_reg :
                               win1 ? fp1_reg : direct_addr;
  wire [PTR_W-1:0] ind_addr  = INSTR_PTR_SEL ? eff1 : eff0;

  assign MEM_RADDR = is_ind ? ind_addr : file_addr;

  // results
  wire [7:0] lsr_result  = {1'b0, MEM_RDATA[7:1]};
  wire [7:0] file_result = is_lsr ? lsr_result : MEM_RDATA;
  wire       file_to_w   = is_file && !INSTR_DEST;
  wire       file_to_f   = is_file && INSTR_DEST;
  wire       result_zero = (is_ind ? MEM_RDATA : file_result) == 8'h00;

  // W: register port write wins over the instruction in the same cycle
  always_comb begin
    w_next = w_reg;
    if (wr_w) begin
      w_next = REG_WDATA;
    end else if (file_to_w) begin
      w_next = file_result;
    end else if (is_ind) begin
      w_next = MEM_RDATA;
    end else if (is_wlit) begin
      w_next = INSTR_LIT;
    end
  end

  // flags: literal loads never reach here, so they keep C and Z
  always_comb begin
    c_next = c_reg;
    z_next = z_reg;
    if (wr_status) begin
      c_next = REG_WDATA[smx_pkg::STAT_C_BIT];
      z_next = REG_WDATA[smx_pkg::STAT_Z_BIT];
    end else if (is_lsr) begin
      c_next = MEM_RDATA[0];
      z_next = result_zero;
    end else if (is_mov || is_ind) begin
      z_next = result_zero;
    end
  end

  assign bank_next = wr_bank ? REG_WDATA[smx_pkg::BANK_W-1:0] :
                     is_bank ? INSTR_LIT[smx_pkg::BANK_W-1:0] : bank_reg;
  assign page_next = wr_page ? REG_WDATA[smx_pkg::PAGE_W-1:0] :
                     is_page ? INSTR_LIT[smx_pkg::PAGE_W-1:0] : page_reg;

  // pointers: byte writes from the port, else the stepper result
  always_comb begin
    fp0_next = fp0_reg;
    fp1_next = fp1_reg;
    if (wr_fp0_lo) begin
      fp0_next = {fp0_reg[PTR_W-1:8], REG_WDATA};
    end else if (wr_fp0_hi) begin
      fp0_next = {REG_WDATA, fp0_reg[7:0]};
    end else if (is_ind && !INSTR_PTR_SEL) begin
      fp0_next = step0;
    end
    if (wr_fp1_lo) begin
      fp1_next = {fp1_reg[PTR_W-1:8], REG_WDATA};
    end else if (wr_fp1_hi) begin
      fp1_next = {REG_WDATA, fp1_reg[7:0]};
    end else if (is_ind && INSTR_PTR_SEL) begin
      fp1_next = step1;
    end
  end

  assign retired_next = is_known ? retired_reg + 8'h01 : retired_reg;

  // read mux, unmapped offsets read zero
  assign rdata_next =
    !REG_RD                            ? 8'h00 :
    (REG_ADDR == smx_pkg::REG_W)       ? w_reg :
    (REG_ADDR == smx_pkg::REG_STATUS)  ? {6'h00, z_reg, c_reg} :
    (REG_ADDR == smx_pkg::REG_BANK)    ? {3'h0, bank_reg} :
    (REG_ADDR == smx_pkg::REG_PAGE)    ? {1'b0, page_reg} :
    (REG_ADDR == smx_pkg::REG_FP0_LO)  ? fp0_reg[7:0] :
    (REG_ADDR == smx_pkg::REG_FP0_HI)  ? fp0_reg[15:8] :
    (REG_ADDR == smx_pkg::REG_FP1_LO)  ? fp1_reg[7:0] :
    (REG_ADDR == smx_pkg::REG_FP1_HI)  ? fp1_reg[15:8] :
    (REG_ADDR == smx_pkg::REG_RETIRED) ? retired_reg : 8'h00;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      w_reg       <= smx_pkg::W_RST;
      c_reg       <= smx_pkg::C_RST;
      z_reg       <= smx_pkg::Z_RST;
      bank_reg    <= smx_pkg::BANK_RST;
      page_reg    <= smx_pkg::PAGE_RST;
      fp0_reg     <= '0;
      fp1_reg     <= '0;
      retired_reg <= smx_pkg::RETIRED_RST;
      rdata_reg   <= 8'h00;
    end else begin
      w_reg       <= w_next;
      c_reg       <= c_next;
      z_reg       <= z_next;
      bank_reg    <= bank_next;
      page_reg    <= page_next;
      fp0_reg     <= fp0_next;
      fp1_reg     <= fp1_next;
      retired_reg <= retired_next;
      rdata_reg   <= rdata_next;
    end
  end

  // write-back issued one cycle later so memory sees stable data;
  // no stall needed because the read already happened this cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_reg      <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_waddr_reg <= '0;
      mem_wdata_reg <= 8'h00;
    end else begin
      done_reg      <= is_known;
      mem_we_reg    <= file_to_f;
      mem_waddr_reg <= file_addr;
      mem_wdata_reg <= file_result;
    end
  end

  assign INSTR_DONE = done_reg;
  assign MEM_WE     = mem_we_reg;
  assign MEM_WADDR  = mem_waddr_reg;
  assign MEM_WDATA  = mem_wdata_reg;
  assign W_OUT      = w_reg;
  assign C_FLAG     = c_reg;
  assign Z_FLAG     = z_reg;
  assign BANK_OUT   = bank_reg;
  assign PAGE_OUT   = page_reg;
  assign REG_RDATA  = rdata_reg;

  // checks
  chk_lsr_shift_dest: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_lsr && INSTR_DEST |=> MEM_WE && MEM_WDATA == {1'b0, $past(MEM_RDATA[7:1])})
    else $error("shift write-back value wrong");

  chk_lsr_carry_out: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_lsr && !wr_status |=> C_FLAG == $past(MEM_RDATA[0]))
    else $error("shift carry not bit 0");

  chk_lsr_to_w: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_lsr && !INSTR_DEST && !wr_w |=> !MEM_WE && W_OUT[7] == 1'b0 &&
      W_OUT[6:0] == $past(MEM_RDATA[7:1]))
    else $error("shift to W wrong");

  chk_move_zero_test: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_mov && !wr_status |=> Z_FLAG == ($past(MEM_RDATA) == 8'h00))
    else $error("move zero flag wrong");

  chk_move_rewrite: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_mov && INSTR_DEST && !wr_w |=> MEM_WADDR == $past(MEM_RADDR) &&
      MEM_WDATA == $past(MEM_RDATA) && $stable(W_OUT))
    else $error("move rewrite wrong");

  chk_window_redirect: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_file && INSTR_FILE == smx_pkg::WIN1_FILE |-> MEM_RADDR == fp1_reg)
    else $error("window not redirected");

  chk_ind_pre_inc: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_ind && !INSTR_REL && !INSTR_PTR_SEL && INSTR_MODE == smx_pkg::MODE_PRE_INC
      |-> MEM_RADDR == PTR_W'(fp0_reg + 1'b1))
    else $error("pre-increment address wrong");

  chk_ind_post_dec: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_ind && !INSTR_REL && INSTR_PTR_SEL && !wr_fp1 &&
      INSTR_MODE == smx_pkg::MODE_POST_DEC
      |-> MEM_RADDR == fp1_reg ##1 fp1_reg == PTR_W'($past(fp1_reg) - 1'b1))
    else $error("post-decrement step wrong");

  chk_ind_rel_hold: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_ind && INSTR_REL && !wr_fp0 && !wr_fp1 |=> $stable(fp0_reg) && $stable(fp1_reg))
    else $error("relative form moved pointer");

  chk_ind_load_w: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_ind && !wr_w && !wr_status |=> W_OUT == $past(MEM_RDATA) &&
      Z_FLAG == (W_OUT == 8'h00))
    else $error("indirect load result wrong");

  chk_literal_flags: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (is_bank || is_page || is_wlit) && !wr_status |=> $stable(C_FLAG) && $stable(Z_FLAG))
    else $error("literal load touched flags");

  chk_literal_bank: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_bank && !wr_bank |=> BANK_OUT == $past(INSTR_LIT[smx_pkg::BANK_W-1:0]))
    else $error("bank literal not loaded");

  chk_literal_w: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_wlit && !wr_w |=> W_OUT == $past(INSTR_LIT))
    else $error("W literal not loaded");

  chk_single_cycle: assert property (
    @(posedge CLK) disable iff (!rst_n)
    is_known |=> INSTR_DONE)
    else $error("instruction not done in one cycle");

endmodule

/* File: sim/smx_core_tb.sv */
// self-checking bench for the shift/move execute block
// assumes smx_pkg is compiled first; the bench models data memory as one known byte
`timescale 1ns/1ps
module smx_core_tb;
  logic        CLK;
  logic        RST_B;
  logic        INSTR_VALID;
  logic [2:0]  INSTR_OP;
  logic        INSTR_DEST;
  logic [6:0]  INSTR_FILE;
  logic [7:0]  INSTR_LIT;
  logic        INSTR_PTR_SEL;
  logic        INSTR_REL;
  logic [1:0]  INSTR_MODE;
  logic        INSTR_DONE;
  logic [15:0] MEM_RADDR;
  logic [7:0]  MEM_RDATA;
  logic        MEM_WE;
  logic [15:0] MEM_WADDR;
  logic [7:0]  MEM_WDATA;
  logic [7:0]  W_OUT;
  logic        C_FLAG;
  logic        Z_FLAG;
  logic [4:0]  BANK_OUT;
  logic [6:0]  PAGE_OUT;
  logic [3:0]  REG_ADDR;
  logic [7:0]  REG_WDATA;
  logic        REG_WR;
  logic        REG_RD;
  logic [7:0]  REG_RDATA;
  logic [15:0] mem_addr;
  logic [7:0]  mem_byte;
  logic [15:0] raddr_seen;
  logic [15:0] waddr_seen;
  logic [7:0]  wdata_seen;
  logic        done_seen;
  logic        we_seen;
  int          error_cnt;
  int          checked;

  // any other address reads the inverse, so a wrong address never passes
  assign MEM_RDATA = (MEM_RADDR === mem_addr) ? mem_byte : ~mem_byte;

  smx_core #(.PTR_W(16)) dut (
    .CLK(CLK), .RST_B(RST_B), .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP),
    .INSTR_DEST(INSTR_DEST), .INSTR_FILE(INSTR_FILE), .INSTR_LIT(INSTR_LIT),
    .INSTR_PTR_SEL(INSTR_PTR_SEL), .INSTR_REL(INSTR_REL), .INSTR_MODE(INSTR_MODE),
    .INSTR_DONE(INSTR_DONE), .MEM_RADDR(MEM_RADDR), .MEM_RDATA(MEM_RDATA),
    .MEM_WE(MEM_WE), .MEM_WADDR(MEM_WADDR), .MEM_WDATA(MEM_WDATA), .W_OUT(W_OUT),
    .C_FLAG(C_FLAG), .Z_FLAG(Z_FLAG), .BANK_OUT(BANK_OUT), .PAGE_OUT(PAGE_OUT),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA));

  always #20 CLK = ~CLK;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD   <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  task automatic set_ptr(input logic sel, input logic [15:0] v);
    reg_wr(sel ? smx_pkg::REG_FP1_LO : smx_pkg::REG_FP0_LO, v[7:0]);
    reg_wr(sel ? smx_pkg::REG_FP1_HI : smx_pkg::REG_FP0_HI, v[15:8]);
  endtask

  task automatic get_ptr(input logic sel, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    reg_rd(sel ? smx_pkg::REG_FP1_LO : smx_pkg::REG_FP0_LO, lo);
    reg_rd(sel ? smx_pkg::REG_FP1_HI : smx_pkg::REG_FP0_HI, hi);
    v = {hi, lo};
  endtask

  // one instruction cycle; the read address is caught before the taking edge
  task automatic exec(input logic [2:0] op, input logic dest, input logic [6:0] f,
                      input logic [7:0] lit, input logic sel, input logic rel,
                      input logic [1:0] md);
    @(posedge CLK);
    INSTR_VALID   <= 1'b1;
    INSTR_OP      <= op;
    INSTR_DEST    <= dest;
    INSTR_FILE    <= f;
    INSTR_LIT     <= lit;
    INSTR_PTR_SEL <= sel;
    INSTR_REL     <= rel;
    INSTR_MODE    <= md;
    #1 raddr_seen = MEM_RADDR;
    @(posedge CLK);
    INSTR_VALID <= 1'b0;
    #1;
    done_seen  = INSTR_DONE;
    we_seen    = MEM_WE;
    waddr_seen = MEM_WADDR;
    wdata_seen = MEM_WDATA;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    reg_rd(smx_pkg::REG_STATUS, d);
    chk(d, 8'h00);
    chk(W_OUT, smx_pkg::W_RST);
    reg_rd(4'hf, d);
    chk(d, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_literals();
    reg_wr(smx_pkg::REG_STATUS, 8'h03);
    exec(smx_pkg::OP_BANK_LIT, 1'b0, 7'h00, 8'hff, 1'b0, 1'b0, 2'h0);
    chk(BANK_OUT, 5'h1f);
    chk(done_seen, 1'b1);
    exec(smx_pkg::OP_PAGE_LIT, 1'b0, 7'h00, 8'hff, 1'b0, 1'b0, 2'h0);
    chk(PAGE_OUT, 7'h7f);
    exec(smx_pkg::OP_W_LIT, 1'b0, 7'h00, 8'ha5, 1'b0, 1'b0, 2'h0);
    chk(W_OUT, 8'ha5);
    chk({C_FLAG, Z_FLAG}, 2'b11);
    $display("test literals done");
  endtask

  // bank is 5'h1f here, so the direct address is {bank, f}
  task automatic t_shift();
    mem_addr = 16'h0fa3;
    mem_byte = 8'h81;
    exec(smx_pkg::OP_LSR, 1'b0, 7'h23, 8'h00, 1'b0, 1'b0, 2'h0);
    chk(raddr_seen, 16'h0fa3);
    chk(W_OUT, 8'h40);
    chk({C_FLAG, Z_FLAG, we_seen}, 3'b100);
    mem_byte = 8'h01;
    exec(smx_pkg::OP_LSR, 1'b1, 7'h23, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({we_seen, C_FLAG, Z_FLAG}, 3'b111);
    chk(waddr_seen, 16'h0fa3);
    chk(wdata_seen, 8'h00);
    chk(W_OUT, 8'h40);
    $display("test shift done");
  endtask

  task automatic t_move();
    mem_addr = 16'h0f85;
    mem_byte = 8'h00;
    exec(smx_pkg::OP_FILE_MOVE, 1'b1, 7'h05, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({we_seen, Z_FLAG}, 2'b11);
    chk(waddr_seen, 16'h0f85);
    chk(W_OUT, 8'h40);
    mem_byte = 8'h7e;
    exec(smx_pkg::OP_FILE_MOVE, 1'b0, 7'h05, 8'h00, 1'b0, 1'b0, 2'h0);
    chk({W_OUT, we_seen, Z_FLAG}, {8'h7e, 2'b00});
    $display("test move done");
  endtask

  task automatic t_modes();
    logic [15:0] p;
    for (int m = 0; m < 4; m++) begin
      set_ptr(1'b0, 16'h1000);
      mem_addr = m[1] ? 16'h1000 : (m[0] ? 16'h0fff : 16'h1001);
      mem_byte = (m == 3) ? 8'h00 : 8'h3c;
      exec(smx_pkg::OP_IND_LOAD, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0, m[1:0]);
      chk(raddr_seen, mem_addr);
      chk({W_OUT, Z_FLAG}, {mem_byte, m == 3});
      get_ptr(1'b0, p);
      chk(p, m[0] ? 16'h0fff : 16'h1001);
    end
    $display("test modes done");
  endtask

  task automatic t_wrap_rel();
    logic [15:0] p;
    set_ptr(1'b1, 16'hffff);
    exec(smx_pkg::OP_IND_LOAD, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0, smx_pkg::MODE_PRE_INC);
    chk(raddr_seen, 16'h0000);
    exec(smx_pkg::OP_IND_LOAD, 1'b0, 7'h00, 8'h00, 1'b1, 1'b0, smx_pkg::MODE_POST_DEC);
    get_ptr(1'b1, p);
    chk(p, 16'hffff);
    set_ptr(1'b1, 16'h0010);
    exec(smx_pkg::OP_IND_LOAD, 1'b0, 7'h00, 8'h20, 1'b1, 1'b1, 2'h0);
    chk(raddr_seen, 16'hfff0);
    exec(smx_pkg::OP_IND_LOAD, 1'b0, 7'h00, 8'h1f, 1'b1, 1'b1, 2'h3);
    chk(raddr_seen, 16'h002f);
    get_ptr(1'b1, p);
    chk(p, 16'h0010);
    $display("test wrap and offset done");
  endtask

  // window addresses follow the pointers and do not step them
  task automatic t_window();
    logic [15:0] p;
    logic [7:0]  d;
    set_ptr(1'b1, 16'h2345);
    mem_addr = 16'h2345;
    mem_byte = 8'h99;
    exec(smx_pkg::OP_FILE_MOVE, 1'b1, smx_pkg::WIN1_FILE, 8'h00, 1'b0, 1'b0, 2'h0);
    chk(raddr_seen, 16'h2345);
    chk(waddr_seen, 16'h2345);
    get_ptr(1'b1, p);
    chk(p, 16'h2345);
    chk(wdata_seen, 8'h99);
    mem_addr = 16'h0fff;
    exec(smx_pkg::OP_LSR, 1'b0, smx_pkg::WIN0_FILE, 8'h00, 1'b0, 1'b0, 2'h0);
    chk(raddr_seen, 16'h0fff);
    chk({W_OUT, C_FLAG}, {8'h4c, 1'b1});
    exec(3'h7, 1'b0, 7'h00, 8'h11, 1'b0, 1'b0, 2'h0);
    chk({done_seen, we_seen, W_OUT}, {2'b00, 8'h4c});
    reg_rd(smx_pkg::REG_RETIRED, d);
    chk(d, 8'h11);
    reg_rd(smx_pkg::REG_PAGE, d);
    chk(d, 8'h7f);
    $display("test window and refused op done");
  endtask

  initial begin
    CLK = 1'b0;
    RST_B = 1'b0;
    INSTR_VALID = 1'b0;
    INSTR_OP = 3'h0;
    INSTR_DEST = 1'b0;
    INSTR_FILE = 7'h00;
    INSTR_LIT = 8'h00;
    INSTR_PTR_SEL = 1'b0;
    INSTR_REL = 1'b0;
    INSTR_MODE = 2'h0;
    REG_ADDR = 4'h0;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    mem_addr = 16'h0000;
    mem_byte = 8'h00;
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge CLK);
    t_reset();
    t_literals();
    t_shift();
    t_move();
    t_modes();
    t_wrap_rel();
    t_window();
    finish_test();
  end

  // guard against a hung run
  initial begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    finish_test();
  end
endmodule
